// ==== include/asrd_pkg.sv ====
// constants, state encoding and register map of the slave address decoder
package asrd_pkg;
    // register byte offsets; the select code is offset bits 3:1
    localparam logic [3:0] ASRD_OFS_ID = 4'h0;
    localparam logic [3:0] ASRD_OFS_TYPE = 4'h2;
    localparam logic [3:0] ASRD_OFS_STATUS = 4'h4;
    localparam logic [3:0] ASRD_OFS_CONTROL = 4'h4;
    localparam logic [3:0] ASRD_OFS_USER0 = 4'h6;
    localparam int ASRD_USER_COUNT = 5;
    localparam int ASRD_SEL_COUNT = 8;
    // second stage compare: {A15, A14, AM5..AM0} against 1110_1X01
    localparam logic [7:0] ASRD_AM_PATTERN = 8'hE9;
    localparam logic [7:0] ASRD_AM_MASK = 8'hFB;
    // identification word, value arbitrary
    localparam logic [15:0] ASRD_ID_VALUE = 16'hA5C3;
    // device type upper byte reads as ones
    localparam logic [7:0] ASRD_TYPE_UPPER = 8'hFF;
    // status register is 8 bits; upper byte reads zero
    localparam logic [7:0] ASRD_STATUS_UPPER = 8'h00;
    // undriven internal bus floats high through pull-ups
    localparam logic [15:0] ASRD_BUS_IDLE = 16'hFFFF;
    localparam logic [7:0] ASRD_CONTROL_RESET = 8'h00;
    localparam logic [15:0] ASRD_BUS_RESET = 16'h0000;
    // status field positions
    localparam int ASRD_SELFTEST_PASSED_BIT = 2;
    localparam int ASRD_EXTENDED_TEST_BIT = 3;
    // transfer acknowledge sequencer, gray along idle-enable-latch-ack-release
    typedef enum logic [2:0] {
        ASRD_ST_IDLE = 3'h0,
        ASRD_ST_ENABLE = 3'h1,
        ASRD_ST_LATCH = 3'h3,
        ASRD_ST_ACK = 3'h2,
        ASRD_ST_RELEASE = 3'h6
    } asrd_state_t;
endpackage

// ==== include/asrd_sel_if.sv ====
// register-select signals between the sequencer and the address decoder
`timescale 1ns/10ps
interface asrd_sel_if;
    logic capture;
    logic release_lat;
    logic active;
    logic [5:1] addr;
    logic lat_a4;
    logic lat_a5;
    logic sel_id;
    logic sel_type;
    logic sel_status;
    logic [4:0] sel_user;
    modport ctl (
        output capture, release_lat, active, addr,
        input lat_a4, lat_a5, sel_id, sel_type, sel_status, sel_user
    );
    modport dec (
        input capture, release_lat, active, addr,
        output lat_a4, lat_a5, sel_id, sel_type, sel_status, sel_user
    );
endinterface

// ==== hdl/asrd_addr_match.sv ====
// two-stage logical address and address-modifier comparator
`timescale 1ns/10ps
module asrd_addr_match import asrd_pkg::*; (
    // backplane lines
    input wire logic [15:6] addr_in,
    input wire logic [5:0] am_in,
    input wire logic iack_n_in,
    input wire logic lword_n_in,
    // switch setting
    input wire logic [7:0] logical_address_switch_in,
    // results
    output logic stage1_match_out,
    output logic card_match_n_out
);
    logic [7:0] am_vec;
    logic stage2_match;

    // interrupt acknowledge cycles bypass normal decoding
    assign stage1_match_out = (addr_in[13:6] == logical_address_switch_in)
        && iack_n_in; // [R1] [R2]
    assign am_vec = {addr_in[15], addr_in[14], am_in};
    // am bit 2 masked so both 29h and 2Dh match
    assign stage2_match = (((am_vec ^ ASRD_AM_PATTERN) & ASRD_AM_MASK) == 8'h00)
        && lword_n_in; // [R3] [R4] [R5]
    assign card_match_n_out = ~(stage1_match_out && stage2_match); // [R2] [R6]
endmodule

// ==== hdl/asrd_reg_decode.sv ====
// register-select address latch and one-of-eight enable decoder
`timescale 1ns/10ps
module asrd_reg_decode import asrd_pkg::*; (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // select signals
    asrd_sel_if.dec sel
);
    logic [5:1] lat_addr;
    logic lat_match;
    logic dec_en;
    logic [ASRD_SEL_COUNT-1:0] one_hot;

    // address held until the sequencer releases it after strobes go high
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            lat_addr <= 5'h00;
            lat_match <= 1'b0;
        end else if (sel.capture) begin
            lat_addr <= sel.addr; // [R7] [R8]
            lat_match <= 1'b1;
        end else if (sel.release_lat) begin
            lat_match <= 1'b0; // [R23]
        end
    end

    assign dec_en = lat_match && sel.active && !lat_addr[5] && !lat_addr[4]; // [R9]

    genvar i;
    generate
        for (i = 0; i < ASRD_SEL_COUNT; i = i + 1) begin : g_sel
            assign one_hot[i] = dec_en && (lat_addr[3:1] == 3'(i)); // [R10]
        end
    endgenerate

    assign sel.sel_id = one_hot[ASRD_OFS_ID[3:1]];
    assign sel.sel_type = one_hot[ASRD_OFS_TYPE[3:1]];
    assign sel.sel_status = one_hot[ASRD_OFS_STATUS[3:1]];
    assign sel.sel_user = one_hot[ASRD_SEL_COUNT-1:ASRD_OFS_USER0[3:1]]; // [R11]
    assign sel.lat_a4 = lat_addr[4]; // [R11]
    assign sel.lat_a5 = lat_addr[5];
endmodule

// ==== hdl/asrd_top.sv ====
// A16/D16 register-based slave: address match, select latch, data steering
//
// What this block does
// R1 - logical address recognised only when A6..A13 equal the address switch
// R2 - first stage matches only with IACK high; it enables stage two
// R3 - second stage accepts AM 29h or 2Dh, AM2 ignored, fixed pattern
// R4 - A14 and A15 must both be high for a valid access
// R5 - access decoded only while LWORD is high (short word)
// R6 - both stages matching drives the card-match low, starting a transfer
// R7 - transceiver enable low during transfer also latches A1..A5
// R8 - latched select address stays stable until data strobes go high
// R9 - select decoder enabled only on match with latched A4 and A5 low
// R10 - A3..A1 pick id, device type, status/control, or five user enables
// R11 - five user enables plus latched A4, A5 are offered to user logic
// R12 - both byte transceivers enabled only while enable is low in a transfer
// R13 - write low moves backplane data inward, high drives internal data out
// R14 - backplane write line inverted; user sees only active-high write
// R15 - status read with write high puts eight status inputs on bits 0-7
// R16 - status bit 2 self-test passed, bit 3 low means extended test
// R17 - user logic must hold status inputs stable; no latching here
// R18 - device type read gives switch code low byte, ones in high byte
// R19 - each type bit reads one unless its switch pulls it low
// R20 - type code should avoid the slot 0 reserved range
// R21 - control write captures bits 0-7 on a one-cycle low latch pulse
// R22 - all sequencer signals run on the one system clock
// R23 - hold ack and latch until strobes drop, then release in order
// R24 - controller sets address lines before strobes and holds until ack
`timescale 1ns/10ps
module asrd_top import asrd_pkg::*; (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // backplane address and cycle control
    input wire logic [15:1] addr_in,
    input wire logic [5:0] am_in,
    input wire logic iack_n_in,
    input wire logic lword_n_in,
    input wire logic as_n_in,
    input wire logic ds0_n_in,
    input wire logic ds1_n_in,
    input wire logic write_n_in,
    // backplane data lines, one enable per byte transceiver
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic [1:0] data_oe_n_out,
    // transfer acknowledge, open drain
    input wire logic dtack_in,
    output logic dtack_out,
    output logic dtack_oe_n_out,
    // configuration switches
    input wire logic [7:0] logical_address_switch_in,
    input wire logic [7:0] type_code_switch_in,
    // user side inputs
    input wire logic dtack_inhibit_in,
    input wire logic [7:0] status_inputs_in,
    input wire logic [15:0] user_data_in,
    // user side outputs
    output logic write_out,
    output logic card_match_n_out,
    output logic transceiver_enable_n_out,
    output logic control_latch_n_out,
    output logic [4:0] user_enable_n_out,
    output logic latched_a4_out,
    output logic latched_a5_out,
    output logic [15:0] internal_data_bus_out,
    output logic [7:0] control_outputs_out
);
    asrd_state_t state;
    asrd_state_t next_state;
    logic wr_q;
    logic [15:0] int_bus;
    logic [15:0] next_int_bus;
    logic [7:0] control;
    logic strobes_active;
    logic strobes_gone;
    logic start;
    logic tx_active;
    logic ack_active;
    logic latch_pulse;
    logic ctrl_write;
    logic card_match_n;
    logic [15:0] rd_mux;
    logic [15:0] status_word;
    logic [15:0] type_word;

    asrd_sel_if sel ();

    asrd_addr_match u_match (
        .addr_in(addr_in[15:6]),
        .am_in(am_in),
        .iack_n_in(iack_n_in),
        .lword_n_in(lword_n_in),
        .logical_address_switch_in(logical_address_switch_in),
        .stage1_match_out(),
        .card_match_n_out(card_match_n)
    );

    asrd_reg_decode u_decode (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .sel(sel)
    );

    // either strobe marks a D16 cycle; a single byte lane is still a cycle
    assign strobes_active = !ds0_n_in || !ds1_n_in;
    assign strobes_gone = ds0_n_in && ds1_n_in;
    assign start = !card_match_n && strobes_active && !as_n_in; // [R6]

    // sequencer: one clock for every transfer signal
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= ASRD_ST_IDLE;
        end else begin
            state <= next_state; // [R22]
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            ASRD_ST_IDLE: begin
                if (start) begin
                    next_state = ASRD_ST_ENABLE; // [R6]
                end
            end
            ASRD_ST_ENABLE: begin
                // inhibit parks the cycle with bus enabled and address held
                if (dtack_inhibit_in) begin
                    next_state = ASRD_ST_ENABLE;
                end else if (wr_q) begin
                    next_state = ASRD_ST_LATCH;
                end else begin
                    next_state = ASRD_ST_ACK;
                end
            end
            ASRD_ST_LATCH: begin
                next_state = ASRD_ST_ACK; // [R21]
            end
            ASRD_ST_ACK: begin
                if (strobes_gone) begin
                    next_state = ASRD_ST_RELEASE; // [R23]
                end
            end
            ASRD_ST_RELEASE: begin
                next_state = ASRD_ST_IDLE; // [R23]
            end
            default: begin
                next_state = ASRD_ST_IDLE;
            end
        endcase
    end

    assign tx_active = (state == ASRD_ST_ENABLE) || (state == ASRD_ST_LATCH)
        || (state == ASRD_ST_ACK); // [R7] [R12]
    // acknowledge is held one state past the transceiver shutdown
    assign ack_active = (state == ASRD_ST_ACK) || (state == ASRD_ST_RELEASE); // [R23]
    assign latch_pulse = (state == ASRD_ST_LATCH); // [R21]

    // direction caught at cycle start so a late write edge cannot flip it
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_q <= 1'b0;
        end else if (state == ASRD_ST_IDLE && start) begin
            wr_q <= !write_n_in; // [R13] [R14]
        end
    end

    // select latch control
    assign sel.capture = (state == ASRD_ST_IDLE) && start; // [R7]
    assign sel.release_lat = (state == ASRD_ST_RELEASE); // [R8] [R23]
    assign sel.active = tx_active;
    assign sel.addr = addr_in[5:1];

    // read sources; status passes straight through, user keeps it stable
    assign status_word = {ASRD_STATUS_UPPER, status_inputs_in}; // [R15] [R16]
    assign type_word = {ASRD_TYPE_UPPER, type_code_switch_in}; // [R18] [R19]

    // writes disable every read source
    assign rd_mux = wr_q ? ASRD_BUS_IDLE
        : sel.sel_status ? status_word // [R15]
        : sel.sel_type ? type_word // [R18]
        : sel.sel_id ? ASRD_ID_VALUE
        : (|sel.sel_user) ? user_data_in
        : ASRD_BUS_IDLE;

    assign next_int_bus = wr_q ? data_in : rd_mux; // [R13]

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            int_bus <= ASRD_BUS_RESET;
        end else if (tx_active && strobes_active) begin
            // held once strobes rise; backplane data is stale by then
            int_bus <= next_int_bus; // [R13]
        end
    end

    // control captured at the rising end of the one-cycle latch pulse
    assign ctrl_write = latch_pulse && sel.sel_status && wr_q; // [R21]

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            control <= ASRD_CONTROL_RESET;
        end else if (ctrl_write) begin
            control <= data_in[7:0]; // [R21]
        end
    end

    // backplane data driven only on reads while transceivers are on
    assign data_out = int_bus; // [R13]
    assign data_oe_n_out = {2{!(tx_active && !wr_q)}}; // [R12] [R13]

    // acknowledge pulls the line low; released by dropping the enable
    assign dtack_out = 1'b0;
    assign dtack_oe_n_out = !ack_active; // [R23]

    // user side
    assign write_out = !write_n_in; // [R14]
    assign card_match_n_out = card_match_n; // [R6]
    assign transceiver_enable_n_out = !tx_active; // [R7] [R12]
    assign control_latch_n_out = !latch_pulse; // [R21]
    assign user_enable_n_out = ~sel.sel_user; // [R11]
    assign latched_a4_out = sel.lat_a4; // [R11]
    assign latched_a5_out = sel.lat_a5; // [R11]
    assign internal_data_bus_out = int_bus;
    assign control_outputs_out = control;
endmodule

// ==== tb/asrd_top_sva.sv ====
// assertion checker for the slave address decoder top
`timescale 1ns/10ps
module asrd_top_sva import asrd_pkg::*; (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // backplane
    input wire logic [15:1] addr_in,
    input wire logic [5:0] am_in,
    input wire logic iack_n_in,
    input wire logic lword_n_in,
    input wire logic as_n_in,
    input wire logic ds0_n_in,
    input wire logic ds1_n_in,
    input wire logic write_n_in,
    input wire logic [15:0] data_in,
    input wire logic [1:0] data_oe_n_out,
    input wire logic dtack_oe_n_out,
    // switches and user side
    input wire logic [7:0] logical_address_switch_in,
    input wire logic dtack_inhibit_in,
    input wire logic write_out,
    input wire logic card_match_n_out,
    input wire logic transceiver_enable_n_out,
    input wire logic control_latch_n_out,
    input wire logic [4:0] user_enable_n_out,
    input wire logic latched_a4_out,
    input wire logic latched_a5_out,
    input wire logic [7:0] control_outputs_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    wire strobe = !as_n_in && !(ds0_n_in && ds1_n_in);
    wire am_ok = (am_in & ASRD_AM_MASK[5:0]) == ASRD_AM_PATTERN[5:0];
    wire hit = addr_in[13:6] == logical_address_switch_in && iack_n_in && &addr_in[15:14]
        && am_ok && lword_n_in;
    wire idle = dtack_oe_n_out && transceiver_enable_n_out;
    sequence s_take;
        idle && !card_match_n_out && strobe && !dtack_inhibit_in;
    endsequence
    sequence s_drop;
        !dtack_oe_n_out && !transceiver_enable_n_out && ds0_n_in && ds1_n_in;
    endsequence
    sequence s_free;
        transceiver_enable_n_out && &data_oe_n_out ##1 dtack_oe_n_out;
    endsequence
    AST_MATCH: assert property (card_match_n_out == !hit)
        else $error("card match disagrees with address lines");
    AST_IACK: assert property (!iack_n_in |-> card_match_n_out)
        else $error("match during interrupt acknowledge");
    AST_READ: assert property ((s_take and write_n_in) |->
        ##1 dtack_oe_n_out ##1 !dtack_oe_n_out)
        else $error("read acknowledge not two cycles after start");
    AST_WRITE: assert property ((s_take and !write_n_in && addr_in[5:1] == 5'h02) |->
        ##1 !transceiver_enable_n_out ##1 !control_latch_n_out ##1 !dtack_oe_n_out)
        else $error("write sequence out of order");
    AST_CTL: assert property (!control_latch_n_out && addr_in[5:1] == 5'h02 |=>
        control_outputs_out == $past(data_in[7:0]))
        else $error("control not captured from data");
    AST_PULSE: assert property ($fell(control_latch_n_out) |=> control_latch_n_out)
        else $error("latch pulse longer than one cycle");
    AST_OE: assert property (data_oe_n_out != 2'b11 |->
        !transceiver_enable_n_out && write_n_in)
        else $error("data driven outside a read transfer");
    AST_HOLD: assert property (!dtack_oe_n_out && !transceiver_enable_n_out && strobe |=>
        !dtack_oe_n_out)
        else $error("acknowledge dropped while strobes low");
    AST_FREE: assert property (s_drop |=> s_free)
        else $error("release order wrong");
    AST_LAT: assert property ($past(!transceiver_enable_n_out) && !transceiver_enable_n_out
        |-> $stable({latched_a4_out, latched_a5_out}))
        else $error("latched select moved in transfer");
    AST_USER: assert property (user_enable_n_out != 5'h1f |->
        !latched_a4_out && !latched_a5_out && !transceiver_enable_n_out)
        else $error("user enable without valid select");
    AST_WR: assert property (write_out == !write_n_in)
        else $error("write indication not inverted");
endmodule
bind asrd_top asrd_top_sva i_asrd_top_sva (.sys_clk_in, .rst_in, .addr_in, .am_in, .iack_n_in,
    .lword_n_in, .as_n_in, .ds0_n_in, .ds1_n_in, .write_n_in, .data_in, .data_oe_n_out,
    .dtack_oe_n_out, .logical_address_switch_in, .dtack_inhibit_in, .write_out,
    .card_match_n_out, .transceiver_enable_n_out, .control_latch_n_out, .user_enable_n_out,
    .latched_a4_out, .latched_a5_out, .control_outputs_out);

// ==== tb/asrd_ctl_model.sv ====
// backplane system controller model issuing cycles with LWORD and IACK set per call
`timescale 1ns/10ps
module asrd_ctl_model (
    // clock and answer
    input wire logic clk_in,
    input wire logic dtack_n_in,
    input wire logic [15:0] bus_in,
    // backplane drive
    output logic [15:1] addr_out,
    output logic [5:0] am_out,
    output logic iack_n_out,
    output logic lword_n_out,
    output logic as_n_out,
    output logic ds0_n_out,
    output logic ds1_n_out,
    output logic write_n_out,
    output logic [15:0] data_out
);
    // released lines float high on the terminators
    task automatic idle();
        {addr_out, am_out, iack_n_out, lword_n_out} = '1;
        {as_n_out, ds0_n_out, ds1_n_out, write_n_out, data_out} = '1;
    endtask
    initial idle();
    task automatic cyc(input logic w, input logic [15:1] a, input logic [5:0] m,
        input logic [1:0] lk, input int dly, input logic [15:0] wd,
        output logic [15:0] rd, output int n);
        @(negedge clk_in);
        {lword_n_out, iack_n_out} = lk;
        addr_out = a;
        am_out = m;
        write_n_out = !w;
        data_out = w ? wd : 16'hFFFF;
        as_n_out = 1'b0;
        repeat (dly + 1) @(negedge clk_in);
        {ds0_n_out, ds1_n_out} = 2'b00;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
            rd = bus_in;
        end while (dtack_n_in && n < 20);
        // address may go invalid once acknowledged
        @(negedge clk_in);
        {addr_out, am_out} = '1;
        @(negedge clk_in);
        idle();
        repeat (4) if (!dtack_n_in) @(posedge clk_in);
    endtask
endmodule

// ==== tb/tb_top.sv ====
// self-checking bench for the slave address decoder
`timescale 1ns/10ps
module tb_top import asrd_pkg::*; ;
    localparam logic [7:0] LA = 8'h5A;
    logic sys_clk_in, rst_in, iack_n_in, lword_n_in, as_n_in, ds0_n_in, ds1_n_in, write_n_in;
    logic dtack_in, dtack_out, dtack_oe_n_out, dtack_inhibit_in, write_out, card_match_n_out;
    logic transceiver_enable_n_out, control_latch_n_out, latched_a4_out, latched_a5_out;
    logic [15:1] addr_in;
    logic [5:0] am_in;
    logic [1:0] data_oe_n_out;
    logic [15:0] data_in, data_out, ctl_data, user_data_in, internal_data_bus_out, rd, wd;
    logic [7:0] logical_address_switch_in, type_code_switch_in, status_inputs_in;
    logic [7:0] control_outputs_out;
    logic [4:0] user_enable_n_out, ue_seen;
    logic [5:0] amt [9] = '{6'h29, 6'h2D, 6'h39, 6'h09, 6'h28, 6'h29, 6'h29, 6'h29, 6'h29};
    logic [1:0] lkt [9] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h1, 2'h2, 2'h3, 2'h3};
    int n, mismatches, checks_done;
    // undriven byte lanes read high through pull-ups
    assign data_in = {data_oe_n_out[1] ? ctl_data[15:8] : data_out[15:8],
        data_oe_n_out[0] ? ctl_data[7:0] : data_out[7:0]};
    assign dtack_in = dtack_oe_n_out | dtack_out;
    asrd_top i_asrd_top (.sys_clk_in, .rst_in, .addr_in, .am_in, .iack_n_in, .lword_n_in,
        .as_n_in, .ds0_n_in, .ds1_n_in, .write_n_in, .data_in, .data_out, .data_oe_n_out,
        .dtack_in, .dtack_out, .dtack_oe_n_out, .logical_address_switch_in,
        .type_code_switch_in, .dtack_inhibit_in, .status_inputs_in, .user_data_in, .write_out,
        .card_match_n_out, .transceiver_enable_n_out, .control_latch_n_out,
        .user_enable_n_out, .latched_a4_out, .latched_a5_out, .internal_data_bus_out,
        .control_outputs_out);
    asrd_ctl_model i_asrd_ctl_model (.clk_in(sys_clk_in), .dtack_n_in(dtack_in),
        .bus_in(data_in), .addr_out(addr_in), .am_out(am_in), .iack_n_out(iack_n_in),
        .lword_n_out(lword_n_in), .as_n_out(as_n_in), .ds0_n_out(ds0_n_in),
        .ds1_n_out(ds1_n_in), .write_n_out(write_n_in), .data_out(ctl_data));
    initial begin
        sys_clk_in = 1'b0;
        forever #10 sys_clk_in = ~sys_clk_in;
    end
    always @(posedge sys_clk_in) if (!transceiver_enable_n_out) ue_seen <= user_enable_n_out;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [15:1] ad(input logic [7:0] la, input logic [4:0] r);
        return {2'b11, la, r};
    endfunction
    task automatic rw(input logic w, input logic [4:0] r, input logic [15:0] wd);
        i_asrd_ctl_model.cyc(w, ad(LA, r), 6'h29, 2'b11, 0, wd, rd, n);
    endtask
    task automatic conclude();
        $display("checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        #100000;
        mismatches++;
        conclude();
    end
    initial begin
        {rst_in, dtack_inhibit_in, mismatches, checks_done} = '0;
        rst_in = 1'b1;
        {logical_address_switch_in, type_code_switch_in} = {LA, 8'h3C};
        {status_inputs_in, user_data_in} = {8'h04, 16'h1234};
        repeat (5) @(negedge sys_clk_in);
        rst_in = 1'b0;
        chk({8'h00, control_outputs_out}, {8'h00, ASRD_CONTROL_RESET});
        rw(1'b0, 5'h00, 16'h0);
        chk(rd, ASRD_ID_VALUE);
        chk(16'(n), 16'h3);
        rw(1'b0, 5'h01, 16'h0);
        chk(rd, {ASRD_TYPE_UPPER, 8'h3C});
        for (int k = 0; k < 2; k++) begin
            @(negedge sys_clk_in);
            status_inputs_in = 8'h04 << k;
            rw(1'b0, 5'h02, 16'h0);
            chk(rd, {ASRD_STATUS_UPPER, 8'h04 << k});
        end
        rw(1'b1, 5'h02, 16'hC3A5);
        chk({8'h00, control_outputs_out}, 16'h00A5);
        chk(16'(n), 16'h4);
        rw(1'b1, 5'h12, 16'h005A);
        chk({8'h00, control_outputs_out}, 16'h00A5);
        rw(1'b0, 5'h08, 16'h0);
        chk(rd, ASRD_BUS_IDLE);
        for (int k = 0; k < ASRD_USER_COUNT; k++) begin
            wd = (k % 2) ? 16'hBE00 + 16'(k) : user_data_in;
            rw(1'(k % 2), 5'(k + 3), wd);
            chk((k % 2) ? internal_data_bus_out : rd, wd);
            chk({11'h0, ue_seen}, 16'(5'h1f ^ (5'h1 << k)));
        end
        for (int k = 0; k < 9; k++) begin
            i_asrd_ctl_model.cyc(1'b0, k == 7 ? ad(8'h5B, 5'h0) : ad(LA, 5'h0) ^ 15'(k / 8 << 14),
                amt[k], lkt[k], k % 3, 16'h0, rd, n);
            chk(16'(n < 20), 16'(k < 2));
        end
        @(negedge sys_clk_in);
        dtack_inhibit_in = 1'b1;
        fork
            rw(1'b0, 5'h00, 16'h0);
            begin
                repeat (6) @(negedge sys_clk_in);
                dtack_inhibit_in = 1'b0;
            end
        join
        chk(16'(n > 4), 16'h1);
        chk(rd, ASRD_ID_VALUE);
        conclude();
    end
endmodule
